/* design/hsts_top.sv */
// Handshake input status register block with APB slave
// Assumes APB master on pclk; modem pins asynchronous
//
// Notes on behaviour
// [R1] Status register is read-only; writes leave it unchanged.
// [R2] Bit 0 sets on any CTS change, clears on read, resets zero.
// [R3] Bit 1 sets on any DSR change, clears on read, resets zero.
// [R4] Bit 2 sets only on RI rising; clears on read.
// [R5] Bit 3 sets on any DCD change, clears on read.
// [R6] Bit 4 is inverted CTS pin, or control bit 1 in loopback.
// [R7] Bit 5 is inverted DSR pin, or control bit 0 in loopback.
// [R8] Bit 6 is inverted RI pin, or control bit 2 in loopback.
// [R9] Bit 7 is inverted DCD pin, or control bit 3 in loopback.
// [R10] Flags clear after the read, which returns old values.
// [R11] Inputs synchronised; event during clearing read keeps its flag.
`timescale 1ns/10ps
`include "hsts_consts.svh"
module hsts_top
  import hsts_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Modem input pins
  input  wire logic        cts_pin,
  input  wire logic        dsr_pin,
  input  wire logic        ri_pin,
  input  wire logic        dcd_pin,
  // Modem output pins
  output logic             dtr_pin,
  output logic             rts_pin,
  output logic             out1_pin,
  output logic             out2_pin
);

  hsts_apb_req_t req_w;
  hsts_apb_rsp_t rsp_q;
  hsts_state_t   state_q;
  hsts_lines_t   pins_w;
  hsts_lines_t   sync_w;
  hsts_lines_t   status_lvl_w;
  logic [3:0]    flags_w;
  logic [4:0]    ctl_q;
  logic          loop_w;
  logic          access_w;
  logic          rd_status_w;
  logic [3:0]    clr_mask_w;
  logic          wr_ctl_w;
  logic          mapped_w;
  logic [7:0]    status_w;

  // ----------------------------------------------------------------
  // Bus request bundle
  // ----------------------------------------------------------------
  always_comb begin
    req_w.psel    = psel;
    req_w.penable = penable;
    req_w.pwrite  = pwrite;
    req_w.paddr   = paddr;
    req_w.pwdata  = pwdata;
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_comb begin
    pins_w.cts = cts_pin;
    pins_w.dsr = dsr_pin;
    pins_w.ri  = ri_pin;
    pins_w.dcd = dcd_pin;
  end

  hsts_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pins    (pins_w),
    .sync_q  (sync_w)
  );

  // ----------------------------------------------------------------
  // Status levels: inverted pins, or control outputs in loopback
  // ----------------------------------------------------------------
  assign loop_w = ctl_q[`HSTS_CTL_LOOP_BIT];

  always_comb begin
    if (loop_w) begin
      status_lvl_w.cts = ctl_q[`HSTS_CTL_RTS_BIT];  // [R6]
      status_lvl_w.dsr = ctl_q[`HSTS_CTL_DTR_BIT];  // [R7]
      status_lvl_w.ri  = ctl_q[`HSTS_CTL_OUT1_BIT]; // [R8]
      status_lvl_w.dcd = ctl_q[`HSTS_CTL_OUT2_BIT]; // [R9]
    end else begin
      status_lvl_w.cts = ~sync_w.cts; // [R6]
      status_lvl_w.dsr = ~sync_w.dsr; // [R7]
      status_lvl_w.ri  = ~sync_w.ri;  // [R8]
      status_lvl_w.dcd = ~sync_w.dcd; // [R9]
    end
  end

  // ----------------------------------------------------------------
  // Change flags
  // ----------------------------------------------------------------
  hsts_detect u_detect (
    .pclk    (pclk),
    .presetn (presetn),
    .lvl     (status_lvl_w),
    .clear   (clr_mask_w),
    .flags_q (flags_w)
  );

  assign status_w = {status_lvl_w, flags_w};

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign access_w = req_w.psel & req_w.penable &
                    (state_q == HSTS_ACCESS);
  assign mapped_w = (req_w.paddr == `HSTS_STATUS_OFS) |
                    (req_w.paddr == `HSTS_CONTROL_OFS) |
                    (req_w.paddr == `HSTS_LEVEL_OFS);
  assign rd_status_w = access_w & ~req_w.pwrite &
                       (req_w.paddr == `HSTS_STATUS_OFS); // [R10]
  // Clear only flags the read reported; later events stay pending
  assign clr_mask_w = {4{rd_status_w}} & rsp_q.prdata[3:0]; // [R10]
  assign wr_ctl_w = access_w & req_w.pwrite & pstrb[0] &
                    (req_w.paddr == `HSTS_CONTROL_OFS);

  // ----------------------------------------------------------------
  // Slave state: setup cycle, then one access cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= HSTS_IDLE;
    end else begin
      case (state_q)
        HSTS_IDLE: begin
          if (req_w.psel && !req_w.penable) begin
            state_q <= HSTS_ACCESS;
          end
        end
        HSTS_ACCESS: begin
          state_q <= HSTS_IDLE;
        end
        default: begin
          state_q <= HSTS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data, latched at end of setup so access shows old flags
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_q <= '0;
    end else if (req_w.psel && !req_w.penable) begin
      rsp_q.pslverr <= ~mapped_w;
      rsp_q.pready  <= 1'b1;
      if (req_w.pwrite) begin
        rsp_q.prdata <= 32'h0000_0000;
      end else if (req_w.paddr == `HSTS_STATUS_OFS) begin
        rsp_q.prdata <= {24'h00_0000, status_w};
      end else if (req_w.paddr == `HSTS_CONTROL_OFS) begin
        rsp_q.prdata <= {27'h000_0000, ctl_q};
      end else if (req_w.paddr == `HSTS_LEVEL_OFS) begin
        rsp_q.prdata <= {28'h000_0000, sync_w};
      end else begin
        rsp_q.prdata <= 32'h0000_0000;
      end
    end else if (access_w) begin
      rsp_q.pready <= 1'b0;
    end
  end

  assign pready  = (state_q == HSTS_ACCESS) & rsp_q.pready;
  assign pslverr = (state_q == HSTS_ACCESS) & rsp_q.pslverr;
  assign prdata  = rsp_q.prdata;

  // ----------------------------------------------------------------
  // Handshake output control register; status takes no writes
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= `HSTS_CONTROL_RST;
    end else if (wr_ctl_w) begin
      ctl_q <= req_w.pwdata[4:0]; // [R1]
    end
  end

  // ----------------------------------------------------------------
  // Modem outputs, active low, held inactive in loopback
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dtr_pin  <= 1'b1;
      rts_pin  <= 1'b1;
      out1_pin <= 1'b1;
      out2_pin <= 1'b1;
    end else begin
      dtr_pin  <= loop_w | ~ctl_q[`HSTS_CTL_DTR_BIT];
      rts_pin  <= loop_w | ~ctl_q[`HSTS_CTL_RTS_BIT];
      out1_pin <= loop_w | ~ctl_q[`HSTS_CTL_OUT1_BIT];
      out2_pin <= loop_w | ~ctl_q[`HSTS_CTL_OUT2_BIT];
    end
  end

endmodule

/* design/hsts_consts.svh */
// Constants for the handshake input status block
// Assumes inclusion by bare name from design files
`ifndef HSTS_CONSTS_SVH
`define HSTS_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define HSTS_STATUS_OFS   32'h4000_8018
`define HSTS_CONTROL_OFS  32'h4000_801C
`define HSTS_LEVEL_OFS    32'h4000_8020

// ----------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------
`define HSTS_CTS_CHG_BIT  0
`define HSTS_DSR_CHG_BIT  1
`define HSTS_RI_RISE_BIT  2
`define HSTS_DCD_CHG_BIT  3
`define HSTS_CTS_LVL_BIT  4
`define HSTS_DSR_LVL_BIT  5
`define HSTS_RI_LVL_BIT   6
`define HSTS_DCD_LVL_BIT  7

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define HSTS_CTL_DTR_BIT  0
`define HSTS_CTL_RTS_BIT  1
`define HSTS_CTL_OUT1_BIT 2
`define HSTS_CTL_OUT2_BIT 3
`define HSTS_CTL_LOOP_BIT 4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HSTS_FLAGS_RST    4'h0
`define HSTS_CONTROL_RST  5'h00
`define HSTS_SYNC_RST     4'hF
`define HSTS_LEVEL_RST    4'h0

`endif

/* design/hsts_pkg.sv */
// Types for the handshake input status block
// Assumes the consts header is compiled alongside
package hsts_pkg;

  // ----------------------------------------------------------------
  // Four modem input lines, order CTS, DSR, RI, DCD as bits 0..3
  // ----------------------------------------------------------------
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } hsts_lines_t;

  // ----------------------------------------------------------------
  // APB request and answer
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } hsts_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } hsts_apb_rsp_t;

  // ----------------------------------------------------------------
  // Bus slave states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HSTS_IDLE   = 2'b01,
    HSTS_ACCESS = 2'b10
  } hsts_state_t;

endpackage

/* design/hsts_sync.sv */
// Two-flop synchroniser, one per modem input line
// Assumes asynchronous pin levels and idle-high lines
`timescale 1ns/10ps
`include "hsts_consts.svh"
module hsts_sync
  import hsts_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Lines
  input  wire hsts_lines_t pins,
  output hsts_lines_t      sync_q
);

  hsts_lines_t meta_q;

  // ----------------------------------------------------------------
  // Two stages per bit
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_q[i] <= 1'b1;
          sync_q[i] <= 1'b1;
        end else begin
          meta_q[i] <= pins[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule

/* design/hsts_detect.sv */
// Change detection and sticky flags for the modem inputs
// Assumes synchronised inputs and a one-cycle per-flag clear mask
`timescale 1ns/10ps
`include "hsts_consts.svh"
module hsts_detect
  import hsts_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Observed levels and clear
  input  wire hsts_lines_t lvl,
  input  wire logic [3:0]  clear,
  // Flags
  output logic [3:0]       flags_q
);

  hsts_lines_t prev_q;
  logic [3:0]  event_w;

  // ----------------------------------------------------------------
  // Previous sample
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= `HSTS_LEVEL_RST;
    end else begin
      prev_q <= lvl; // [R11]
    end
  end

  // ----------------------------------------------------------------
  // Events: both edges, ring on its input rising (status bit falls)
  // ----------------------------------------------------------------
  always_comb begin
    event_w[`HSTS_CTS_CHG_BIT] = lvl.cts ^ prev_q.cts; // [R2]
    event_w[`HSTS_DSR_CHG_BIT] = lvl.dsr ^ prev_q.dsr; // [R3]
    event_w[`HSTS_RI_RISE_BIT] = ~lvl.ri & prev_q.ri; // [R4]
    event_w[`HSTS_DCD_CHG_BIT] = lvl.dcd ^ prev_q.dcd; // [R5]
  end

  // ----------------------------------------------------------------
  // Sticky flags, set wins over clear
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_flag
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flags_q[i] <= 1'b0; // [R2]
        end else if (event_w[i]) begin
          flags_q[i] <= 1'b1; // [R11]
        end else if (clear[i]) begin
          flags_q[i] <= 1'b0; // [R10]
        end
      end
    end
  endgenerate

endmodule

/* tb/hsts_modem_model.sv */
// Modem side model driving the four handshake input pins
// Assumes idle-high lines; slow mode lags each request by four cycles
`timescale 1ns/10ps
module hsts_modem_model
  import hsts_pkg::*;
(
  // Clock and pace
  input  wire logic        pclk,
  input  wire logic        slow,
  // Requested levels and pins
  input  wire logic [3:0]  want,
  output hsts_lines_t      pins
);
  logic [15:0] dly_q = 16'hFFFF;
  initial pins = 4'hF;
  always @(posedge pclk) begin
    dly_q <= {dly_q[11:0], want};
    pins  <= slow ? dly_q[15:12] : want;
  end
endmodule

/* tb/hsts_top_sva.sv */
// Checker for the handshake status block, bound to its top module
// Assumes the APB master keeps setup and access order
`timescale 1ns/10ps
`include "hsts_consts.svh"
module hsts_top_sva
  import hsts_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // Modem pins
  input wire logic        cts_pin,
  input wire logic        dsr_pin,
  input wire logic        ri_pin,
  input wire logic        dcd_pin,
  input wire logic        dtr_pin,
  input wire logic        rts_pin,
  input wire logic        out1_pin,
  input wire logic        out2_pin
);
  logic       acc, rd_st, wr_ctl, chg, loop_q, clr_ok_q;
  logic [3:0] ctl_q, pins_q, pins;
  logic [2:0] quiet_q;
  assign acc    = psel && penable;
  assign rd_st  = acc && !pwrite && paddr == `HSTS_STATUS_OFS;
  assign wr_ctl = acc && pwrite && paddr == `HSTS_CONTROL_OFS && pstrb[0];
  assign pins   = {dcd_pin, ri_pin, dsr_pin, cts_pin};
  assign chg    = pins != pins_q || wr_ctl;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {loop_q, ctl_q} <= 5'h00;
    end else if (wr_ctl) begin
      {loop_q, ctl_q} <= pwdata[4:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_q   <= 4'hF;
      quiet_q  <= 3'h0;
      clr_ok_q <= 1'b0;
    end else begin
      pins_q   <= pins;
      quiet_q  <= chg ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
      clr_ok_q <= !chg && (clr_ok_q || (rd_st && quiet_q >= 3'h5));
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_access:
    assert property (acc |-> pready) else $error("pready low in access");
  a_ready_idle:
    assert property (!acc |-> !pready) else $error("pready outside access");
  a_err_unmapped:
    assert property (acc && paddr != `HSTS_STATUS_OFS
      && paddr != `HSTS_CONTROL_OFS && paddr != `HSTS_LEVEL_OFS |-> pslverr)
      else $error("no error on unmapped address");
  a_upper_zero:
    assert property (rd_st |-> prdata[31:8] == 24'h000000)
      else $error("status upper bits set");
  a_level_pins:
    assert property (rd_st && !loop_q && quiet_q >= 3'h5
      |-> prdata[7:4] == ~pins) else $error("level differs from pins");
  a_level_loop:
    assert property (rd_st && loop_q && quiet_q >= 3'h5
      |-> prdata[7:4] == {ctl_q[3], ctl_q[2], ctl_q[0], ctl_q[1]})
      else $error("loopback level wrong");
  a_flag_cleared:
    assert property (rd_st && clr_ok_q |-> prdata[3:0] == 4'h0)
      else $error("flag not cleared by read");
  a_outs_follow:
    assert property (wr_ctl |-> ##2 {out2_pin, out1_pin, rts_pin, dtr_pin}
      == (loop_q ? 4'hF : ~ctl_q)) else $error("modem outputs wrong");
endmodule

bind hsts_top hsts_top_sva sva_u (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .pready, .pslverr, .prdata, .cts_pin, .dsr_pin,
  .ri_pin, .dcd_pin, .dtr_pin, .rts_pin, .out1_pin, .out2_pin);

/* tb/hsts_top_tb.sv */
// Self-checking bench for the handshake status block
// Assumes design, checker and modem model are compiled first
`timescale 1ns/10ps
`include "hsts_consts.svh"
module hsts_top_tb
  import hsts_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, slow = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdat;
  logic [3:0]  pstrb = 4'hF, want = 4'hF;
  logic        pready, pslverr, serr, dtr_pin, rts_pin, out1_pin, out2_pin;
  hsts_lines_t pins;
  int          fails = 0, n_compared = 0, cyc = 0;
  hsts_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .pslverr, .prdata, .cts_pin(pins.cts),
    .dsr_pin(pins.dsr), .ri_pin(pins.ri), .dcd_pin(pins.dcd), .dtr_pin,
    .rts_pin, .out1_pin, .out2_pin);
  hsts_modem_model modem_u (.pclk, .slow, .want, .pins);
  always #2 pclk = ~pclk;
  // ----
  // Bus and compare tasks
  // ----
  task automatic complete_run;
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      complete_run;
    end
  end
  task automatic xfer(input logic wr, input logic [31:0] a, d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // ----
  // Test sequence
  // ----
  initial begin
    logic [7:0] e;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(0, `HSTS_STATUS_OFS, 0);
    chk(rdat, 32'h0);
    xfer(0, 32'h4000_8024, 0);
    chk({31'h0, serr}, 32'h1);
    xfer(1, `HSTS_STATUS_OFS, 32'hFF);
    xfer(0, `HSTS_STATUS_OFS, 0);
    chk(rdat, 32'h0);
    for (int k = 0; k < 8; k++) begin
      slow <= k[0];
      want[k % 4] <= (k > 3);
      repeat (12) @(posedge pclk);
      e = {~want, 4'h0};
      e[k % 4] = (k % 4 != 2) || (k > 3);
      xfer(0, `HSTS_STATUS_OFS, 0);
      chk(rdat, {24'h0, e});
      xfer(0, `HSTS_STATUS_OFS, 0);
      chk(rdat, {24'h0, e[7:4], 4'h0});
    end
    slow <= 1'b0;
    want[1] <= 1'b0;
    repeat (2) @(posedge pclk);
    xfer(0, `HSTS_STATUS_OFS, 0);
    chk(rdat, 32'h0);
    xfer(0, `HSTS_STATUS_OFS, 0);
    chk(rdat, 32'h22);
    want <= 4'h0;
    for (int j = 0; j < 4; j++) begin
      xfer(1, `HSTS_CONTROL_OFS, 32'h10 | (32'h1 << j));
      repeat (8) @(posedge pclk);
      chk({out2_pin, out1_pin, rts_pin, dtr_pin}, 32'hF);
      e = j < 2 ? 8'h20 >> j : 8'h10 << j;
      xfer(0, `HSTS_STATUS_OFS, 0);
      chk(rdat & 32'hF0, {24'h0, e});
    end
    xfer(1, `HSTS_CONTROL_OFS, 32'h05);
    pstrb <= 4'h0;
    xfer(1, `HSTS_CONTROL_OFS, 32'h00);
    pstrb <= 4'hF;
    repeat (8) @(posedge pclk);
    chk({out2_pin, out1_pin, rts_pin, dtr_pin}, 32'hA);
    xfer(0, `HSTS_CONTROL_OFS, 0);
    chk(rdat, 32'h05);
    xfer(0, `HSTS_STATUS_OFS, 0);
    chk(rdat & 32'hF0, 32'hF0);
    complete_run;
  end
endmodule
